/* hw/bos_decoder.sv */
`timescale 1ns/100ps
module bos_decoder (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // instruction from fetch, one per instruction cycle
  input wire logic instr_valid,
  input wire logic [bos_pkg::INSTR_W-1:0] instr,
  // file register writes from the rest of the core
  input wire logic load_en,
  input wire logic [bos_pkg::ADDR_W-1:0] load_addr,
  input wire logic [bos_pkg::DATA_W-1:0] load_data,
  // file register write made by a bit instruction
  output logic wr_en,
  output logic [bos_pkg::ADDR_W-1:0] wr_addr,
  output logic [bos_pkg::DATA_W-1:0] wr_data,
  // retirement report
  output logic retire,
  output bos_pkg::bos_op_t retire_op,
  output logic [bos_pkg::BIT_W-1:0] retire_bit,
  output logic skip_taken,
  output logic squashed
);

  // whole pipe state; one register and one next-value copy
  typedef struct packed {
    logic e_valid;
    bos_pkg::bos_op_t e_op;
    logic [bos_pkg::ADDR_W-1:0] e_addr;
    logic [bos_pkg::BIT_W-1:0] e_bit;
    logic e_squash;
    logic wr_en;
    logic [bos_pkg::ADDR_W-1:0] wr_addr;
    logic [bos_pkg::DATA_W-1:0] wr_data;
    logic retire;
    bos_pkg::bos_op_t retire_op;
    logic [bos_pkg::BIT_W-1:0] retire_bit;
    logic skip_taken;
    logic squashed;
    logic [bos_pkg::DATA_W-1:0] retire_old;
  } bos_state_t;

  bos_state_t st;
  bos_state_t next_st;
  // helpers derived from the state and the word in decode
  logic [bos_pkg::DATA_W-1:0] ram_rdata;
  logic [bos_pkg::DATA_W-1:0] e_mask;
  logic [bos_pkg::DATA_W-1:0] r_mask;
  logic [3:0] d_nib;
  bos_pkg::bos_op_t d_op;
  logic skip_now;
  logic mem_we;
  logic [bos_pkg::ADDR_W-1:0] mem_waddr;
  logic [bos_pkg::DATA_W-1:0] mem_wdata;

  // opcode field of the word in decode; bit masks of the execute and retire slots
  assign d_nib = instr[bos_pkg::OPC_LSB +: 4];
  assign e_mask = bos_pkg::BIT_ONE << st.e_bit;
  assign r_mask = bos_pkg::BIT_ONE << st.retire_bit;

  // opcode classing; other opcodes belong to neighbouring decoders
  always_comb begin
    if (d_nib == bos_pkg::NIB_CLEAR) begin
      d_op = bos_pkg::BOS_OP_CLEAR;
    end else if (d_nib == bos_pkg::NIB_SET) begin
      d_op = bos_pkg::BOS_OP_SET;
    end else if (d_nib == bos_pkg::NIB_TEST) begin
      d_op = bos_pkg::BOS_OP_TEST;
    end else begin
      d_op = bos_pkg::BOS_OP_NONE;
    end
  end

  // test result decided in execute while the next word sits in decode
  // the nop slot is forced even when the fetch side offered an idle cycle there
  assign skip_now = st.e_valid && (st.e_op == bos_pkg::BOS_OP_TEST) && !ram_rdata[st.e_bit];

  // next-state logic for the two-stage decode/execute pipe
  always_comb begin
    next_st = st;
    // decode: latch fields, or turn the fetched word into a nop on a skip
    next_st.e_valid = instr_valid && (d_op != bos_pkg::BOS_OP_NONE) && !skip_now;
    next_st.e_squash = skip_now;
    next_st.e_op = d_op;
    next_st.e_addr = instr[bos_pkg::ADDR_LSB +: bos_pkg::ADDR_W];
    next_st.e_bit = instr[bos_pkg::BIT_LSB +: bos_pkg::BIT_W];
    // execute: read-modify-write touches only the chosen bit
    next_st.wr_en = st.e_valid && ((st.e_op == bos_pkg::BOS_OP_CLEAR) || (st.e_op == bos_pkg::BOS_OP_SET));
    next_st.wr_addr = st.e_addr;
    if (st.e_op == bos_pkg::BOS_OP_SET) begin
      next_st.wr_data = ram_rdata | e_mask;
    end else begin
      next_st.wr_data = ram_rdata & ~e_mask;
    end
    // report; no status flag is ever driven from here
    next_st.retire = st.e_valid;
    next_st.retire_op = st.e_op;
    next_st.retire_bit = st.e_bit;
    next_st.skip_taken = skip_now;
    next_st.squashed = st.e_squash;
    next_st.retire_old = ram_rdata;
  end

  // bit instruction wins over a core load in the same cycle; the load is dropped
  // known limit: the core must not aim a load at a cycle that carries a bit write
  always_comb begin
    mem_we = next_st.wr_en || load_en;
    if (next_st.wr_en) begin
      mem_waddr = next_st.wr_addr;
      mem_wdata = next_st.wr_data;
    end else begin
      mem_waddr = load_addr;
      mem_wdata = load_data;
    end
  end

  // state register
  // file contents stay out of reset; they are preloaded through the load port
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // file registers, read address straight from the word in decode
  bos_file_ram #(
    .DEPTH(bos_pkg::FILE_DEPTH),
    .WIDTH(bos_pkg::DATA_W),
    .AW(bos_pkg::ADDR_W)
  ) u_file (
    .clk(clk),
    .wr_en(mem_we),
    .wr_addr(mem_waddr),
    .wr_data(mem_wdata),
    .rd_addr(instr[bos_pkg::ADDR_LSB +: bos_pkg::ADDR_W]),
    .rd_data(ram_rdata)
  );

  // outputs come straight from the state register
  assign wr_en = st.wr_en;
  assign wr_addr = st.wr_addr;
  assign wr_data = st.wr_data;
  assign retire = st.retire;
  assign retire_op = st.retire_op;
  assign retire_bit = st.retire_bit;
  assign skip_taken = st.skip_taken;
  assign squashed = st.squashed;

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  a_field_decode: assert property (
    (instr_valid && (d_op != bos_pkg::BOS_OP_NONE) && !skip_now)
    |=> (st.e_valid && (st.e_addr == $past(instr[4:0])) && (st.e_bit == $past(instr[7:5])))
  ) else $error("bit instruction fields not captured");

  a_clear_bit: assert property (
    (st.retire && (st.retire_op == bos_pkg::BOS_OP_CLEAR))
    |-> (st.wr_en && !st.wr_data[st.retire_bit] && ((st.wr_data | r_mask) == (st.retire_old | r_mask)))
  ) else $error("clear did not clear exactly the chosen bit");

  a_set_bit: assert property (
    (st.retire && (st.retire_op == bos_pkg::BOS_OP_SET))
    |-> (st.wr_en && st.wr_data[st.retire_bit] && ((st.wr_data & ~r_mask) == (st.retire_old & ~r_mask)))
  ) else $error("set did not set exactly the chosen bit");

  a_write_source: assert property (
    st.wr_en |-> (st.retire && ((st.retire_op == bos_pkg::BOS_OP_CLEAR) || (st.retire_op == bos_pkg::BOS_OP_SET)))
  ) else $error("file write without clear or set");

  a_skip_zero: assert property (
    (st.retire && (st.retire_op == bos_pkg::BOS_OP_TEST)) |-> (st.skip_taken == !st.retire_old[st.retire_bit])
  ) else $error("skip decision does not follow tested bit");

  a_skip_nop: assert property (
    st.skip_taken |=> (st.squashed && !st.retire && !st.wr_en)
  ) else $error("skipped slot did not become a nop");

  a_skip_cycles: assert property (
    (st.retire && (st.retire_op == bos_pkg::BOS_OP_TEST) && !st.skip_taken) |=> !st.squashed
  ) else $error("untaken test cost a second cycle");

  a_single_cycle: assert property (
    (st.retire && (st.retire_op != bos_pkg::BOS_OP_TEST)) |-> (!st.skip_taken ##1 !st.squashed)
  ) else $error("clear or set took more than one cycle");

  // skips and nop slots must come from a test, never from stale state
  a_skip_source: assert property (
    st.skip_taken |-> (st.retire && (st.retire_op == bos_pkg::BOS_OP_TEST))
  ) else $error("skip raised outside a test retire");

  a_squash_source: assert property (
    st.squashed |-> $past(st.skip_taken)
  ) else $error("nop slot without a preceding skip");

  // idle slots and foreign opcodes must leave the execute stage empty
  a_foreign_ignored: assert property (
    (!instr_valid || (d_op == bos_pkg::BOS_OP_NONE)) |=> !st.e_valid
  ) else $error("foreign or idle word entered execute");

  // a test only reads; it must never reach the file write port
  a_test_no_write: assert property (
    (st.retire && (st.retire_op == bos_pkg::BOS_OP_TEST)) |-> !st.wr_en
  ) else $error("test instruction wrote a file register");

  // fixed answer time: a taken word retires exactly two edges later with its own bit
  a_answer_latency: assert property (
    (instr_valid && (d_op != bos_pkg::BOS_OP_NONE) && !skip_now) |-> ##2 (st.retire && (st.retire_bit == $past(instr[7:5], 2)))
  ) else $error("bit instruction did not retire on time");

  a_write_addr: assert property (
    st.wr_en |-> (st.wr_addr == $past(instr[4:0], 2))
  ) else $error("file write went to the wrong register");

  // scenarios worth seeing in coverage
  c_clear: cover property (st.retire && (st.retire_op == bos_pkg::BOS_OP_CLEAR));
  c_set_then_clear: cover property (
    (st.retire && (st.retire_op == bos_pkg::BOS_OP_SET)) ##1 (st.retire && (st.retire_op == bos_pkg::BOS_OP_CLEAR))
  );
  c_skip: cover property (st.skip_taken ##1 st.squashed);
  c_no_skip: cover property (st.retire && (st.retire_op == bos_pkg::BOS_OP_TEST) && !st.skip_taken);
  c_load_dropped: cover property (next_st.wr_en && load_en);

endmodule : bos_decoder

/* hw/bos_pkg.sv */
// What this block does
// - each bit instruction carries a five-bit file address (0 to 31) and a three-bit bit position (0 to 7).
// - opcode nibble 0100 writes zero into the chosen bit of the addressed register and keeps the other bits.
// - opcode nibble 0101 writes one into the chosen bit of the addressed register and keeps the other bits.
// - opcode nibble 0110 tests the chosen bit and skips the next instruction only when that bit is zero.
// - a taken skip throws away the instruction fetched meanwhile and runs a no-operation in its place.
// - the test instruction takes two cycles when it skips and one cycle when it does not.
package bos_pkg;

  // instruction word layout
  localparam int INSTR_W = 12;
  localparam int ADDR_W = 5;
  localparam int BIT_W = 3;
  localparam int DATA_W = 8;
  localparam int FILE_DEPTH = 32;
  localparam int OPC_LSB = 8;
  localparam int BIT_LSB = 5;
  localparam int ADDR_LSB = 0;

  // upper opcode nibbles of the three bit instructions
  localparam logic [3:0] NIB_CLEAR = 4'h4;
  localparam logic [3:0] NIB_SET = 4'h5;
  localparam logic [3:0] NIB_TEST = 4'h6;

  // single-bit mask seed and value after reset
  localparam logic [DATA_W-1:0] BIT_ONE = 8'h01;
  localparam logic [DATA_W-1:0] RST_DATA = 8'h00;

  // executed operation class
  typedef enum logic [1:0] {
    BOS_OP_NONE = 2'b00,
    BOS_OP_CLEAR = 2'b01,
    BOS_OP_SET = 2'b10,
    BOS_OP_TEST = 2'b11
  } bos_op_t;

endpackage : bos_pkg

/* hw/bos_file_ram.sv */
`timescale 1ns/100ps
module bos_file_ram #(
  parameter int DEPTH = 32,
  parameter int WIDTH = 8,
  parameter int AW = 5
) (
  // clock
  input wire logic clk,
  // write side
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // read side, data one cycle later
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  // write-first bypass so a back-to-back read of the same register sees the new value
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    if (wr_en && (wr_addr == rd_addr)) begin
      rd_data <= wr_data;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule : bos_file_ram

/* tb/bit_op_skip_decoder_bench.sv */
`timescale 1ns/100ps
module bit_op_skip_decoder_bench;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic instr_valid = 1'b0;
  logic [bos_pkg::INSTR_W-1:0] instr = 12'h000;
  logic load_en = 1'b0;
  logic [bos_pkg::ADDR_W-1:0] load_addr = 5'h00;
  logic [bos_pkg::DATA_W-1:0] load_data = 8'h00;
  logic wr_en, retire, skip_taken, squashed;
  logic [bos_pkg::ADDR_W-1:0] wr_addr;
  logic [bos_pkg::DATA_W-1:0] wr_data;
  bos_pkg::bos_op_t retire_op;
  logic [bos_pkg::BIT_W-1:0] retire_bit;
  int mismatches = 0;
  int compares = 0;
  int cyc = 0;
  logic [31:0] rnd = 32'h6E55F204;
  logic [7:0] mem [32];
  logic [21:0] exp_q [$];
  int due_q [$];
  logic skip_next = 1'b0;
  logic [21:0] seen;

  bos_decoder i_dut (.clk(clk), .sys_rst(sys_rst), .instr_valid(instr_valid), .instr(instr),
    .load_en(load_en), .load_addr(load_addr), .load_data(load_data), .wr_en(wr_en), .wr_addr(wr_addr),
    .wr_data(wr_data), .retire(retire), .retire_op(retire_op), .retire_bit(retire_bit),
    .skip_taken(skip_taken), .squashed(squashed));

  // 100 ns clock
  initial forever #50 clk = ~clk;

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    lfsr = {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h00000000);
  endfunction : lfsr

  task automatic end_sim();
    if (exp_q.size() != 0) mismatches++;
    $display("mismatches=%0d compares=%0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim

  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %0h seen %0h", name, exp, got);
    end
  endtask : check

  // cycle count and hang guard, sized well above the ~350 cycles of traffic
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      mismatches++;
      end_sim();
    end
  end

  task automatic load(input logic [4:0] a, input logic [7:0] d);
    load_en = 1'b1;
    load_addr = a;
    load_data = d;
    mem[a] = d;
    @(posedge clk);
    #1;
  endtask : load

  // model runs in issue order, so back-to-back hits on one register see forwarded data
  task automatic issue(input logic v, input logic [11:0] w);
    logic [7:0] d;
    logic [2:0] b;
    logic [4:0] a;
    b = w[7:5];
    a = w[4:0];
    d = mem[a];
    if (skip_next) begin
      skip_next = 1'b0;
      exp_q.push_back(22'h000001);
      due_q.push_back(cyc + 2);
    end else if (v && w[11:8] == bos_pkg::NIB_CLEAR) begin
      d[b] = 1'b0;
      mem[a] = d;
      exp_q.push_back({1'b1, bos_pkg::BOS_OP_CLEAR, b, 1'b1, a, d, 2'b00});
      due_q.push_back(cyc + 2);
    end else if (v && w[11:8] == bos_pkg::NIB_SET) begin
      d[b] = 1'b1;
      mem[a] = d;
      exp_q.push_back({1'b1, bos_pkg::BOS_OP_SET, b, 1'b1, a, d, 2'b00});
      due_q.push_back(cyc + 2);
    end else if (v && w[11:8] == bos_pkg::NIB_TEST) begin
      skip_next = ~d[b];
      exp_q.push_back({1'b1, bos_pkg::BOS_OP_TEST, b, 1'b0, 13'h0000, ~d[b], 1'b0});
      due_q.push_back(cyc + 2);
    end
    instr_valid = v;
    instr = w;
    @(posedge clk);
    #1;
  endtask : issue

  // any activity, reset cycles included, must match the oldest note
  always @(negedge clk) begin
    if ((retire | wr_en | skip_taken | squashed) !== 1'b0) begin
      // op and bit of a slot that retires nothing are leftovers and carry no meaning
      seen = {retire, (retire === 1'b1) ? {retire_op, retire_bit} : 5'h00, wr_en,
        (wr_en === 1'b1) ? wr_addr : 5'h00, (wr_en === 1'b1) ? wr_data : 8'h00, skip_taken, squashed};
      if (exp_q.size() == 0) check("spurious", seen, 22'h000000);
      else begin
        check("retire", seen, exp_q.pop_front());
        check("cycle", cyc, due_q.pop_front());
      end
    end
  end

  initial begin
    repeat (6) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    for (int i = 0; i < 32; i++) begin
      rnd = lfsr(rnd);
      load(i[4:0], rnd[7:0]);
    end
    load(5'h03, 8'hC7);
    load(5'h09, 8'h0A);
    load_en = 1'b0;
    // directed: clear, set, plain test, skip with valid and with idle squash slot
    issue(1'b1, 12'h4E3);
    issue(1'b1, 12'h5E9);
    issue(1'b1, 12'h623);
    issue(1'b1, 12'h6E3);
    issue(1'b1, 12'h5E3);
    issue(1'b1, 12'h6E3);
    issue(1'b0, 12'h5E3);
    issue(1'b1, 12'h7E3);
    // a core load meeting a clear's write is dropped, so bit 7 of register 3 stays zero
    issue(1'b1, 12'h4E3);
    load_en = 1'b1;
    load_addr = 5'h03;
    load_data = 8'hFF;
    issue(1'b0, 12'h000);
    load_en = 1'b0;
    issue(1'b1, 12'h6E3);
    // random mix, mostly bit instructions, some idle or foreign words
    for (int i = 0; i < 300; i++) begin
      rnd = lfsr(rnd);
      issue(rnd[12] | rnd[11], {(rnd[1:0] == 2'h3) ? rnd[5:2] : 4'h4 + {2'h0, rnd[1:0]}, rnd[20:13]});
    end
    repeat (4) issue(1'b0, 12'h000);
    end_sim();
  end
endmodule : bit_op_skip_decoder_bench
